/* File: hdl/src_pkg.sv */
// Constants, register map and types of the system reset controller
// Operation
// - Writing one to the soft trigger starts a system reset until sequence ends.
// - Software reset clears all but debug port and brown-out setup; fuses reload.
// - With fuse enabled, a low reset pin holds reset until it goes high.
// - Pin reset clears all but debug port and brown-out setup; fuses reload.
// - Watchdog reset clears all but debug port and brown-out setup; fuses reload.
// - Debug port reset comes only from its port; clears all but port, brown-out.
// - Reset is held while any source, including a low pin, stays active.
// - After release, an initialization runs, lengthened by start-up and CRC fuses.
// - The controller keeps working in every active and sleep mode.
// - A trigger write without a timely unlock has no effect.
// - Cause flags: bit 5 debug, software, watchdog, external, brown-out, bit 0 power-on.
// - Writing one clears a cause flag; power-on clears all flags but power-on.
// - The power-on flag clears only by a software write of one.
// - After power-on only its flag is set until a full boot has run.
// - The soft trigger bit always reads back zero.
// - Brown-out reset clears all but the brown-out setup; fuses reload after.
package src_pkg;

  // Clock
  localparam int unsigned CLOCK_NS         = 50;

  // Register indexes; byte address is four times the index
  localparam logic [2:0]  IDX_CAUSE        = 3'h0;
  localparam logic [2:0]  IDX_SOFT_TRIGGER = 3'h1;
  localparam logic [2:0]  IDX_IRQ_STATUS   = 3'h2;
  localparam logic [2:0]  IDX_IRQ_CLEAR    = 3'h3;
  localparam logic [2:0]  IDX_IRQ_ENABLE   = 3'h4;
  localparam logic [2:0]  IDX_PROTECT      = 3'h5;
  localparam logic [2:0]  IDX_LAST         = 3'h5;

  // Cause flag positions
  localparam int unsigned CAUSE_POWER_ON   = 0;
  localparam int unsigned CAUSE_BROWNOUT   = 1;
  localparam int unsigned CAUSE_EXTERNAL   = 2;
  localparam int unsigned CAUSE_WATCHDOG   = 3;
  localparam int unsigned CAUSE_SOFTWARE   = 4;
  localparam int unsigned CAUSE_DEBUG      = 5;
  localparam int unsigned CAUSE_W          = 6;
  localparam logic [5:0]  CAUSE_RESET      = 6'h01;
  localparam int unsigned SOFT_TRIGGER_BIT = 0;

  // Interrupt status bits
  localparam int unsigned IRQ_BOOT_DONE    = 0;
  localparam int unsigned IRQ_BAD_WRITE    = 1;
  localparam int unsigned IRQ_W            = 2;
  localparam logic [1:0]  IRQ_RESET        = 2'h0;

  // Bus responses
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

  // Timing
  localparam int unsigned INIT_BASE_NS     = 500;
  localparam int unsigned INIT_BASE_CYCLES = (INIT_BASE_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int unsigned PIN_FILTER_NS    = 200;
  localparam int unsigned PIN_FILTER_CYCLES = (PIN_FILTER_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam logic [2:0]  UNLOCK_CYCLES    = 3'h4;

  // Sequencer states
  typedef enum logic [1:0] {
    SRC_RUN,
    SRC_HOLD,
    SRC_INIT,
    SRC_RELOAD
  } src_state_t;

endpackage : src_pkg

/* File: hdl/src_pin_if.sv */
// Filtered reset pin level passed from the pin filter to the sequencer
`timescale 1ns/1ps
`default_nettype none
interface src_pin_if;
  logic pin_level;
  modport filt (output pin_level);
  modport user (input  pin_level);
endinterface : src_pin_if
`default_nettype wire

/* File: hdl/src_pin_filter.sv */
// Three-flop synchroniser and glitch filter for the external reset pin
`timescale 1ns/1ps
`default_nettype none
module src_pin_filter #(
  parameter int unsigned FILTER_CYCLES = src_pkg::PIN_FILTER_CYCLES
) (
  // Clock and reset
  input  wire logic   i_clock,
  input  wire logic   i_resetn,
  // Raw pin, active low
  input  wire logic   i_pin_n,
  // Filtered level
  src_pin_if.filt     pin
);
  logic [2:0] sync_reg;
  logic [7:0] stable_reg;
  logic       level_reg;
  logic       agree;
  logic       differs;

  // Second and third stages agree, and disagree with the output
  assign agree   = (sync_reg[1] == sync_reg[2]);
  assign differs = agree && (sync_reg[2] != level_reg);
  assign pin.pin_level = level_reg;

  // Synchroniser; stage 0 is read only by stage 1
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      sync_reg <= 3'h7;
    end else begin
      sync_reg <= {sync_reg[1:0], i_pin_n};
    end
  end

  // Level changes after it stays different for the filter time
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      stable_reg <= 8'h00;
      level_reg  <= 1'b1;
    end else if (!differs) begin
      stable_reg <= 8'h00;
    end else if (stable_reg >= 8'(FILTER_CYCLES - 1)) begin
      stable_reg <= 8'h00;
      level_reg  <= sync_reg[2];
    end else begin
      stable_reg <= stable_reg + 8'h01;
    end
  end
endmodule : src_pin_filter
`default_nettype wire

/* File: hdl/src_top.sv */
// System reset controller: source gathering, sequencer, cause flags, bus slave
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module src_top #(
  parameter int unsigned ADDR_W      = 8,
  parameter int unsigned CNT_W       = 16,
  parameter int unsigned STEP_CYCLES = 1280,
  parameter int unsigned CRC_CYCLES  = 1024,
  parameter logic [7:0]  UNLOCK_KEY  = 8'h5A  // Arbitrary key value
) (
  // Clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_resetn,
  // Reset sources
  input  wire logic              i_ext_reset_pin_n,
  input  wire logic              i_brownout,
  input  wire logic              i_watchdog_reset,
  input  wire logic              i_debug_port_reset,
  // Fuse values
  input  wire logic              i_ext_reset_fuse_en,
  input  wire logic [2:0]        i_startup_delay_fuse,
  input  wire logic              i_startup_crc_scan_fuse,
  // Reset outputs, fuse reload strobe and interrupt
  output logic                   o_system_reset_n,
  output logic                   o_debug_port_reset_n,
  output logic                   o_brownout_cfg_reset_n,
  output logic                   o_fuse_reload,
  output logic                   o_irq,
  // AXI4-Lite write
  input  wire logic              i_awvalid,
  input  wire logic [ADDR_W-1:0] i_awaddr,
  output logic                   o_awready,
  input  wire logic              i_wvalid,
  input  wire logic [31:0]       i_wdata,
  input  wire logic [3:0]        i_wstrb,
  output logic                   o_wready,
  output logic                   o_bvalid,
  output logic [1:0]             o_bresp,
  input  wire logic              i_bready,
  // AXI4-Lite read
  input  wire logic              i_arvalid,
  input  wire logic [ADDR_W-1:0] i_araddr,
  output logic                   o_arready,
  output logic                   o_rvalid,
  output logic [31:0]            o_rdata,
  output logic [1:0]             o_rresp,
  input  wire logic              i_rready
);
  src_pkg::src_state_t state_reg, state_next;
  logic [CNT_W-1:0]  count_reg;
  logic [5:0]        cause_reg, cause_set, cause_clr;
  logic [1:0]        irq_stat_reg, irq_en_reg, irq_ev, irq_clr;
  logic [2:0]        unlock_reg, bod_sync_reg;
  logic              bod_level_reg, wdt_req_reg, sw_req_reg, boot_done_reg, bod_cycle_reg;
  logic [2:0]        wr_idx_reg, rd_idx_reg;
  logic              wr_map_reg;
  logic [7:0]        wdata_reg;
  logic              wstrb0_reg;
  logic [31:0]       init_len_full;
  logic [CNT_W-1:0]  init_len;
  logic              ext_active, hold_source, any_source;
  logic              wr_fire, wr_cause, wr_trig, wr_prot, wr_clr, wr_en;
  logic              trig_ok, trig_bad;
  logic              ar_fire;
  logic [2:0]        ar_idx;
  logic              ar_map;
  logic [31:0]       rd_mux;
  logic              aw_map;

  src_pin_if pin_bus ();

  // Pin synchroniser and filter
  src_pin_filter #(
    .FILTER_CYCLES (src_pkg::PIN_FILTER_CYCLES)
  ) u_pin_filter (
    .i_clock  (i_clock),
    .i_resetn (i_resetn),
    .i_pin_n  (i_ext_reset_pin_n),
    .pin      (pin_bus)
  );

  // Brown-out level, three flops, change once stages two and three agree
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      bod_sync_reg  <= 3'h0;
      bod_level_reg <= 1'b0;
    end else begin
      bod_sync_reg <= {bod_sync_reg[1:0], i_brownout};
      if (bod_sync_reg[1] == bod_sync_reg[2]) begin
        bod_level_reg <= bod_sync_reg[2];
      end
    end
  end

  // Source gathering; no sleep or clock gate input stops it
  assign ext_active  = i_ext_reset_fuse_en && !pin_bus.pin_level;
  assign hold_source = ext_active || bod_level_reg || i_debug_port_reset;
  assign any_source  = hold_source || wdt_req_reg || sw_req_reg;

  // Initialization length from the fuses
  assign init_len_full = src_pkg::INIT_BASE_CYCLES
                       + 32'(i_startup_delay_fuse) * STEP_CYCLES
                       + (i_startup_crc_scan_fuse ? CRC_CYCLES : 0);
  assign init_len      = init_len_full[CNT_W-1:0];

  // Bus write decode
  assign aw_map   = (i_awaddr[ADDR_W-1:5] == '0) && (i_awaddr[4:2] <= src_pkg::IDX_LAST);
  assign wr_fire  = !o_awready && !o_wready && !o_bvalid;
  assign wr_cause = wr_fire && wr_map_reg && wstrb0_reg && (wr_idx_reg == src_pkg::IDX_CAUSE);
  assign wr_trig  = wr_fire && wr_map_reg && wstrb0_reg
                  && (wr_idx_reg == src_pkg::IDX_SOFT_TRIGGER);
  assign wr_prot  = wr_fire && wr_map_reg && wstrb0_reg && (wr_idx_reg == src_pkg::IDX_PROTECT);
  assign wr_clr   = wr_fire && wr_map_reg && wstrb0_reg && (wr_idx_reg == src_pkg::IDX_IRQ_CLEAR);
  assign wr_en    = wr_fire && wr_map_reg && wstrb0_reg
                  && (wr_idx_reg == src_pkg::IDX_IRQ_ENABLE);

  // Protected trigger: accepted only inside the unlock window
  assign trig_ok  = wr_trig && (unlock_reg != 3'h0)
                  && wdata_reg[src_pkg::SOFT_TRIGGER_BIT];
  assign trig_bad = wr_trig && (unlock_reg == 3'h0);

  // Cause flag set and clear terms; nothing sets until the first boot ends
  assign cause_set = {i_debug_port_reset, sw_req_reg, wdt_req_reg, ext_active,
                      bod_level_reg, 1'b0} & {6{boot_done_reg}};
  assign cause_clr = wr_cause ? wdata_reg[5:0] : 6'h00;

  // Interrupt events and clears
  assign irq_ev  = {trig_bad, state_reg == src_pkg::SRC_RELOAD};
  assign irq_clr = wr_clr ? wdata_reg[1:0] : 2'h0;

  // Unlock window
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      unlock_reg <= 3'h0;
    end else if (wr_prot && (wdata_reg == UNLOCK_KEY)) begin
      unlock_reg <= src_pkg::UNLOCK_CYCLES;
    end else if (wr_trig) begin
      unlock_reg <= 3'h0;
    end else if (unlock_reg != 3'h0) begin
      unlock_reg <= unlock_reg - 3'h1;
    end
  end

  // Latched one-shot requests, set wins over the clear in hold
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      sw_req_reg  <= 1'b0;
      wdt_req_reg <= 1'b0;
    end else begin
      sw_req_reg  <= trig_ok || (sw_req_reg && state_reg != src_pkg::SRC_HOLD);
      wdt_req_reg <= i_watchdog_reset
                  || (wdt_req_reg && state_reg != src_pkg::SRC_HOLD);
    end
  end

  // Sequencer next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      src_pkg::SRC_RUN:    if (any_source) state_next = src_pkg::SRC_HOLD;
      src_pkg::SRC_HOLD:   if (!any_source) state_next = src_pkg::SRC_INIT;
      src_pkg::SRC_INIT: begin
        if (any_source) begin
          state_next = src_pkg::SRC_HOLD;
        end else if (count_reg == '0) begin
          state_next = src_pkg::SRC_RELOAD;
        end
      end
      src_pkg::SRC_RELOAD: state_next = src_pkg::SRC_RUN;
      default:             state_next = src_pkg::SRC_HOLD;
    endcase
  end

  // Sequencer state and init counter; power-on passes hold to load the fuse length
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg <= src_pkg::SRC_HOLD;
      count_reg <= CNT_W'(src_pkg::INIT_BASE_CYCLES);
    end else begin
      state_reg <= state_next;
      if (state_reg != src_pkg::SRC_INIT) begin
        count_reg <= init_len;
      end else if (count_reg != '0) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

  // Boot tracking and brown-out cycle marker
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      boot_done_reg <= 1'b0;
      bod_cycle_reg <= 1'b0;
    end else begin
      if (state_reg == src_pkg::SRC_RELOAD) begin
        boot_done_reg <= 1'b1;
      end
      if (bod_level_reg) begin
        bod_cycle_reg <= 1'b1;
      end else if (state_reg == src_pkg::SRC_RELOAD) begin
        bod_cycle_reg <= 1'b0;
      end
    end
  end

  // Reset outputs and fuse reload strobe
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_system_reset_n       <= 1'b0;
      o_debug_port_reset_n   <= 1'b0;
      o_brownout_cfg_reset_n <= 1'b0;
      o_fuse_reload          <= 1'b0;
    end else begin
      o_system_reset_n       <= (state_next == src_pkg::SRC_RUN);
      o_debug_port_reset_n   <= boot_done_reg && !bod_level_reg
                             && !(bod_cycle_reg && state_reg != src_pkg::SRC_RUN);
      o_brownout_cfg_reset_n <= boot_done_reg || (state_next == src_pkg::SRC_RUN);
      o_fuse_reload          <= (state_reg == src_pkg::SRC_RELOAD);
    end
  end

  // Cause flags, set wins; power-on reset leaves only the power-on flag
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      cause_reg <= src_pkg::CAUSE_RESET;
    end else begin
      cause_reg <= (cause_reg & ~cause_clr) | cause_set;
    end
  end

  // Interrupt status, enable and output
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_stat_reg <= src_pkg::IRQ_RESET;
      irq_en_reg   <= src_pkg::IRQ_RESET;
      o_irq        <= 1'b0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_ev;
      if (wr_en) begin
        irq_en_reg <= wdata_reg[1:0];
      end
      o_irq <= |(irq_stat_reg & irq_en_reg);
    end
  end

  // Write channels: address and data taken in either order
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_awready  <= 1'b1;
      o_wready   <= 1'b1;
      o_bvalid   <= 1'b0;
      o_bresp    <= src_pkg::RESP_OKAY;
      wr_idx_reg <= 3'h0;
      wr_map_reg <= 1'b0;
      wdata_reg  <= 8'h00;
      wstrb0_reg <= 1'b0;
    end else begin
      if (o_awready && i_awvalid) begin
        o_awready  <= 1'b0;
        wr_idx_reg <= i_awaddr[4:2];
        wr_map_reg <= aw_map;
      end
      if (o_wready && i_wvalid) begin
        o_wready   <= 1'b0;
        wdata_reg  <= i_wdata[7:0];
        wstrb0_reg <= i_wstrb[0];
      end
      if (wr_fire) begin
        o_bvalid <= 1'b1;
        o_bresp  <= wr_map_reg ? src_pkg::RESP_OKAY : src_pkg::RESP_SLVERR;
      end else if (o_bvalid && i_bready) begin
        o_bvalid  <= 1'b0;
        o_awready <= 1'b1;
        o_wready  <= 1'b1;
      end
    end
  end

  // Read decode and data selection
  assign ar_fire = o_arready && i_arvalid;
  assign ar_idx  = i_araddr[4:2];
  assign ar_map  = (i_araddr[ADDR_W-1:5] == '0) && (ar_idx <= src_pkg::IDX_LAST);
  assign rd_mux  = !ar_map ? 32'h0000_0000 :
                   (ar_idx == src_pkg::IDX_CAUSE)      ? {26'h000_0000, cause_reg} :
                   (ar_idx == src_pkg::IDX_IRQ_STATUS) ? {30'h0000_0000, irq_stat_reg} :
                   (ar_idx == src_pkg::IDX_IRQ_ENABLE) ? {30'h0000_0000, irq_en_reg} :
                   32'h0000_0000;

  // Read channel, one cycle answer
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_arready  <= 1'b1;
      o_rvalid   <= 1'b0;
      o_rdata    <= 32'h0000_0000;
      o_rresp    <= src_pkg::RESP_OKAY;
      rd_idx_reg <= 3'h0;
    end else if (ar_fire) begin
      o_arready  <= 1'b0;
      o_rvalid   <= 1'b1;
      o_rdata    <= rd_mux;
      o_rresp    <= ar_map ? src_pkg::RESP_OKAY : src_pkg::RESP_SLVERR;
      rd_idx_reg <= ar_idx;
    end else if (o_rvalid && i_rready) begin
      o_rvalid  <= 1'b0;
      o_arready <= 1'b1;
    end
  end

  // Checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);

  a_trig_reads_zero:
    assert property (o_rvalid && rd_idx_reg == src_pkg::IDX_SOFT_TRIGGER |-> o_rdata == 0)
      else $error("soft trigger read not zero");
  a_cause_top_zero:
    assert property (o_rvalid && rd_idx_reg == src_pkg::IDX_CAUSE |-> o_rdata[31:6] == 0)
      else $error("cause upper bits not zero");
  a_locked_no_effect:
    assert property (trig_bad && !sw_req_reg |=> !sw_req_reg)
      else $error("locked trigger write took effect");
  a_unlocked_resets:
    assert property (trig_ok |-> ##[1:3] !o_system_reset_n)
      else $error("unlocked trigger did not reset");
  a_pin_holds_reset:
    assert property (ext_active [*3] |-> state_reg == src_pkg::SRC_HOLD && !o_system_reset_n)
      else $error("low pin not holding reset");
  a_release_starts_init:
    assert property (state_reg == src_pkg::SRC_HOLD && !any_source
                     |=> state_reg == src_pkg::SRC_INIT && count_reg == $past(init_len))
      else $error("init not started with fuse length");
  a_por_flag_sticky:
    assert property (cause_reg[0] && !cause_clr[0] |=> cause_reg[0])
      else $error("power-on flag lost without write");
  a_flag_w1c:
    assert property (cause_clr[4] && !cause_set[4] |=> !cause_reg[4])
      else $error("cause flag not cleared by one");
  a_boot_no_flags:
    assert property (!boot_done_reg |-> cause_reg[5:1] == 5'h00)
      else $error("flag set before first boot");
  a_fuse_reload:
    assert property (state_reg == src_pkg::SRC_RELOAD |=> o_fuse_reload ##1 !o_fuse_reload)
      else $error("fuse reload strobe wrong");
endmodule : src_top
`default_nettype wire

/* File: dv/src_source_model.sv */
// Behavioural model of the reset source circuits around the controller
`timescale 1ns/1ps
`default_nettype none
module src_source_model (
  // Clock
  input  wire logic i_clock,
  // Reset sources
  output logic      o_pin_n,
  output logic      o_brownout,
  output logic      o_watchdog,
  output logic      o_debug
);
  // Idle levels; the pin has a pull-up
  initial begin
    o_pin_n    = 1'b1;
    o_brownout = 1'b0;
    o_watchdog = 1'b0;
    o_debug    = 1'b0;
  end

  // Kind 0 pin, 1 brown-out, 2 watchdog pulse, 3 debug port
  task automatic hold(input int kind, input int len);
    @(posedge i_clock);
    o_pin_n    <= (kind != 0);
    o_brownout <= (kind == 1);
    o_watchdog <= (kind == 2);
    o_debug    <= (kind == 3);
    @(posedge i_clock);
    o_watchdog <= 1'b0;         // Timeout is a single pulse
    repeat (len) @(posedge i_clock);
    o_pin_n    <= 1'b1;
    o_brownout <= 1'b0;
    o_debug    <= 1'b0;
  endtask : hold
endmodule : src_source_model
`default_nettype wire

/* File: dv/tb.sv */
// Self-checking testbench of the system reset controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int         STEP = 4;
  localparam int         CRC  = 3;
  localparam logic [7:0] KEY  = 8'h5A;  // Arbitrary key value
  logic        i_clock = 1'b0;
  logic        i_resetn = 1'b0;
  logic        fuse_en = 1'b1;
  logic        crc_fuse = 1'b0;
  logic [2:0]  delay_fuse = 3'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rd;
  logic [1:0]  resp;
  wire logic   pin_n, brownout_detector, wdt, dbg, sys_n, dbg_n, bcfg_n, reload, irq;
  wire logic   awready, wready, bvalid, arready, rvalid;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  int          mismatches = 0;
  int          tests_run = 0;
  int          reloads = 0;

  // Clock and fuse reload pulse count
  always #25 i_clock = ~i_clock;
  always @(posedge reload) reloads++;

  src_source_model i_src (.i_clock(i_clock), .o_pin_n(pin_n), .o_brownout(brownout_detector),
    .o_watchdog(wdt), .o_debug(dbg));

  src_top #(.STEP_CYCLES(STEP), .CRC_CYCLES(CRC), .UNLOCK_KEY(KEY)) i_dut (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_ext_reset_pin_n(pin_n),
    .i_brownout(brownout_detector), .i_watchdog_reset(wdt), .i_debug_port_reset(dbg),
    .i_ext_reset_fuse_en(fuse_en), .i_startup_delay_fuse(delay_fuse),
    .i_startup_crc_scan_fuse(crc_fuse), .o_system_reset_n(sys_n),
    .o_debug_port_reset_n(dbg_n), .o_brownout_cfg_reset_n(bcfg_n),
    .o_fuse_reload(reload), .o_irq(irq), .i_awvalid(awvalid), .i_awaddr(awaddr),
    .o_awready(awready), .i_wvalid(wvalid), .i_wdata(wdata), .i_wstrb(4'hF),
    .o_wready(wready), .o_bvalid(bvalid), .o_bresp(bresp), .i_bready(bready),
    .i_arvalid(arvalid), .i_araddr(araddr), .o_arready(arready), .o_rvalid(rvalid),
    .o_rdata(rdata), .o_rresp(rresp), .i_rready(rready));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic finish_test();
    if (mismatches == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  // Write: both channels offered together, each dropped when taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clock);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge i_clock);
      n++;
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    resp = bresp;
    bready <= 1'b0;
    if (n >= 50) check(0, 1, "write hang");
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge i_clock);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge i_clock);
      n++;
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    rd   = rdata;
    resp = rresp;
    rready <= 1'b0;
    if (n >= 50) check(0, 1, "read hang");
  endtask : axi_read

  task automatic wait_sys(input logic lvl, output int n);
    n = 0;
    while (sys_n !== lvl && n < 400) begin
      @(posedge i_clock);
      n++;
    end
    if (n >= 400) check(0, 1, "reset wait");
  endtask : wait_sys

  task automatic cause_check(input logic [31:0] exp);
    axi_read(8'h00);
    check(rd, exp, "cause flags");
    axi_write(8'h00, exp);
    axi_read(8'h00);
    check(rd, 32'h0000_0000, "cause clear");
  endtask : cause_check

  task automatic run_source(input int kind, input int len, input int pos, input logic en_n);
    int n;
    int r0;
    r0 = reloads;
    fork
      i_src.hold(kind, len);
    join_none
    wait_sys(1'b0, n);
    repeat (2) @(posedge i_clock);
    check(dbg_n, en_n, "debug port reset");
    check(bcfg_n, 1'b1, "brown-out cfg reset");
    wait_sys(1'b1, n);
    check(n + 4 >= len + src_pkg::INIT_BASE_CYCLES, 1'b1, "reset too short");
    check(reloads, r0 + 1, "fuse reload");
    cause_check(32'h1 << pos);
  endtask : run_source

  task automatic t_boot();
    int n;
    wait_sys(1'b1, n);
    check(bcfg_n, 1'b1, "boot done");
    check(reloads, 1, "boot reload");
    axi_read(8'h00);
    check(rd, 32'h0000_0001, "only power-on flag");
    axi_read(8'h04);
    check(rd, 32'h0000_0000, "trigger reads zero");
    axi_read(8'h18);
    check(rd, 32'h0000_0000, "unmapped read data");
    check(resp, src_pkg::RESP_SLVERR, "unmapped read");
    cause_check(32'h0000_0001);
  endtask : t_boot

  task automatic t_locked();
    int r0;
    r0 = reloads;
    axi_write(8'h04, 32'h0000_0001);
    repeat (20) @(posedge i_clock);
    check(reloads, r0, "locked write reset");
    axi_read(8'h08);
    check(rd[1], 1'b1, "locked status");
    check(irq, 1'b0, "irq masked");
    axi_write(8'h10, 32'h0000_0002);
    repeat (3) @(posedge i_clock);
    check(irq, 1'b1, "irq raised");
    axi_write(8'h0C, 32'h0000_0002);
    repeat (3) @(posedge i_clock);
    check(irq, 1'b0, "irq cleared");
    axi_write(8'h40, 32'h0000_0001);
    check(resp, src_pkg::RESP_SLVERR, "unmapped write");
  endtask : t_locked

  task automatic t_soft();
    int n;
    int r0;
    r0 = reloads;
    axi_write(8'h14, {24'h0, KEY});
    axi_write(8'h04, 32'h0000_0001);
    wait_sys(1'b0, n);
    check(n < 4, 1'b1, "soft reset late");
    check(dbg_n, 1'b1, "debug port kept");
    check(bcfg_n, 1'b1, "brown-out cfg kept");
    wait_sys(1'b1, n);
    check(reloads, r0 + 1, "soft reload");
    cause_check(32'h0000_0010);
  endtask : t_soft

  task automatic t_pin();
    int r0;
    r0 = reloads;
    fuse_en <= 1'b0;
    i_src.hold(0, 20);
    repeat (12) @(posedge i_clock);  // Filtered level back high first
    fuse_en <= 1'b1;
    i_src.hold(0, 0);
    repeat (12) @(posedge i_clock);
    check(reloads, r0, "pin off or glitch");
    run_source(0, 20, 2, 1'b1);
  endtask : t_pin

  task automatic measure(output int len);
    int n;
    fork
      i_src.hold(2, 0);
    join_none
    wait_sys(1'b0, n);
    wait_sys(1'b1, len);
    axi_write(8'h00, 32'h0000_0008);
  endtask : measure

  task automatic t_init_len();
    int a;
    int b;
    measure(a);
    delay_fuse <= 3'h2;
    crc_fuse   <= 1'b1;
    measure(b);
    check(b - a, 2 * STEP + CRC, "init length");
    delay_fuse <= 3'h0;
    crc_fuse   <= 1'b0;
  endtask : t_init_len

  task automatic t_por2();
    int n;
    measure(n);
    i_src.hold(2, 0);
    wait_sys(1'b0, n);
    wait_sys(1'b1, n);
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_clock);
    check({dbg_n, bcfg_n}, 2'b00, "power-on resets all");
    i_resetn <= 1'b1;
    wait_sys(1'b1, n);
    axi_read(8'h00);
    check(rd, 32'h0000_0001, "power-on clears flags");
  endtask : t_por2

  // Main sequence
  initial begin
    repeat (8) @(posedge i_clock);
    i_resetn <= 1'b1;
    t_boot();
    t_locked();
    t_soft();
    t_pin();
    run_source(2, 2, 3, 1'b1);
    run_source(3, 6, 5, 1'b1);
    run_source(1, 6, 1, 1'b0);
    t_init_len();
    t_por2();
    finish_test();
  end

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge i_clock);
    mismatches++;
    finish_test();
  end
endmodule : tb
`default_nettype wire
